// >>> rbd_board.sv
// rbd_board: board side of the reset lines and the event pins.
// assumes pull-ups on both open-drain reset lines; debug equipment drives
// only pins that the device leaves as inputs.
`timescale 1ns/1ps
`default_nettype none
module rbd_board
  import rbd_pkg::*;
(
  input wire logic hard_out,
  input wire logic hard_oe_n,
  input wire logic soft_out,
  input wire logic soft_oe_n,
  input wire logic ext_hard_n,
  input wire logic ext_soft_n,
  output logic hard_n,
  output logic soft_n,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] equip_drive,
  output logic [NUM_PINS-1:0] pin_level
);
  // wired-and of pull-up, board switch and device pull-down
  assign hard_n = ext_hard_n & (hard_oe_n | hard_out);
  assign soft_n = ext_soft_n & (soft_oe_n | soft_out);
  assign pin_level = (pin_oe_n & equip_drive) | (~pin_oe_n & pin_out);
endmodule : rbd_board
`default_nettype wire

// >>> rbd_pkg.sv
// rbd_pkg: constants, register map and carrier types of the reset, boot
// strap and debug event pin block.
// assumes one 20 MHz system clock and an Avalon-MM register master.
package rbd_pkg;

  // register byte addresses
  localparam logic [3:0] REG_DIR = 4'h0;
  localparam logic [3:0] REG_FUNC = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;

  localparam int NUM_PINS = 7;
  localparam int NUM_ADDR_CH = 6;
  localparam int NUM_EVT_PINS = 5;

  // event pin indices
  localparam int EV_ZERO = 0;
  localparam int EV_ONE = 1;
  localparam int EV_TWO = 2;
  localparam int EV_THREE = 3;
  localparam int EV_FOUR = 4;
  localparam int EV_FIVE = 5;
  localparam int EV_DATA = 6;

  // per-pin input function select, 2 bits per pin for pins zero..four
  localparam logic [1:0] SEL_CHAN = 2'h0;
  localparam logic [1:0] SEL_EVENT = 2'h1;
  localparam logic [1:0] SEL_ALT = 2'h2;
  localparam int FUNC_W = 11;
  localparam int FUNC_ONE_ACK = 10;

  // reset values
  localparam logic [NUM_PINS-1:0] DIR_RESET = 7'h00;
  localparam logic [FUNC_W-1:0] FUNC_RESET = 11'h000;
  localparam logic [NUM_PINS-1:0] OE_N_ALL = 7'h7F;

  // status register field positions
  localparam int ST_RST_LSB = 0;
  localparam int ST_BOOT_LSB = 2;
  localparam int ST_DBG = 4;
  localparam int ST_HOST = 5;
  localparam int ST_BUS32 = 6;
  localparam int ST_PIN_LSB = 7;

  typedef enum logic [1:0] {RST_RUN, RST_SOFT, RST_HARD, RST_POR} rbd_rst_e;

  // signals from the core and its event detection channels
  typedef struct packed {
    logic [NUM_ADDR_CH-1:0] addr_detect;
    logic data_detect;
    logic debug_ack;
    logic debug_rcv_read;
    logic debug_xmt_write;
  } rbd_core_in_s;

  // signals to the core and its event detection channels
  typedef struct packed {
    logic [NUM_ADDR_CH-1:0] addr_chan_enable;
    logic data_chan_enable;
    logic [NUM_EVT_PINS-1:0] debug_event;
    logic debug_req;
    logic event_counter_enable;
  } rbd_core_out_s;

endpackage : rbd_pkg

// >>> rbd_top.sv
// rbd_top: reset state selection, power-on straps and event pin logic.
// assumes pins arrive asynchronously and are synchronised here; registers
// are reached over Avalon-MM with waitrequest on clk_sys.
//
// Operation
// - debug request sampled at power-on release enters debug
// - event pins default inputs, each switchable output
// - pin zero input: debug request, channel, or event
// - pin zero output: channel 0 detection
// - pin one input: channel 1 or event
// - pin one output: debug acknowledge or channel 1
// - pin two input: channel 2, event, or counter
// - pin two output: channel 2 detection
// - pin three input: channel 3 or event
// - pin three output: debug receive register read
// - pin four input: channel 4 or event
// - pin four output: debug transmit register written
// - pin five input: channel 5 enable only
// - pin five output: channel 5 detection
// - data pin input enables data channel
// - data pin output: data channel match
// - host enable during power-on: host port, 32-bit bus
// - boot mode taken at power-on release
// - power-on reset input holds power-on state
// - hard reset line gives hard reset state
// - soft reset line gives soft reset state
`timescale 1ns/1ps
`default_nettype none
module rbd_top
  import rbd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic power_on_reset_n_in,
  input wire logic hard_reset_line_in_n,
  output logic hard_reset_line_out,
  output logic hard_reset_line_oe_n,
  input wire logic soft_reset_line_in_n,
  output logic soft_reset_line_out,
  output logic soft_reset_line_oe_n,
  input wire logic debug_request_in,
  input wire logic host_port_enable_in,
  input wire logic [1:0] boot_mode_in,
  input wire logic [NUM_PINS-1:0] event_pin_in,
  output logic [NUM_PINS-1:0] event_pin_out,
  output logic [NUM_PINS-1:0] event_pin_oe_n,
  input wire rbd_core_in_s core_in,
  output rbd_core_out_s core_out,
  output rbd_rst_e reset_state,
  output logic debug_mode,
  output logic [1:0] boot_mode,
  output logic host_port_on,
  output logic bus_is_32,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  typedef struct packed {
    logic por_s1;
    logic por_s2;
    logic por_d;
    logic hrd_s1;
    logic hrd_s2;
    logic srs_s1;
    logic srs_s2;
    logic dbr_s1;
    logic dbr_s2;
    logic hpe_s1;
    logic hpe_s2;
    logic [1:0] btm_s1;
    logic [1:0] btm_s2;
    logic [NUM_PINS-1:0] pin_s1;
    logic [NUM_PINS-1:0] pin_s2;
    rbd_rst_e rst_st;
    logic drv_hrd;
    logic drv_srs;
    logic dbg_mode;
    logic [1:0] boot;
    logic host_on;
    logic [NUM_PINS-1:0] dir;
    logic [FUNC_W-1:0] func;
    logic [NUM_PINS-1:0] pin_out;
    rbd_core_out_s cout;
    logic ack;
    logic [31:0] rdata;
  } rbd_state_s;

  rbd_state_s st_ff;
  rbd_state_s nxt_st;

  logic [NUM_PINS-1:0] out_src;
  logic [NUM_PINS-1:0] in_act;
  logic [NUM_ADDR_CH-1:0] chan_en;
  logic [NUM_EVT_PINS-1:0] evt_req;
  logic [NUM_EVT_PINS-1:0] alt_req;
  logic bus_req;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  // output sources per event pin
  always_comb begin
    out_src[EV_ZERO] = core_in.addr_detect[0];
    out_src[EV_ONE] = st_ff.func[FUNC_ONE_ACK] ? core_in.debug_ack
                                               : core_in.addr_detect[1];
    out_src[EV_TWO] = core_in.addr_detect[2];
    out_src[EV_THREE] = core_in.debug_rcv_read;
    out_src[EV_FOUR] = core_in.debug_xmt_write;
    out_src[EV_FIVE] = core_in.addr_detect[5];
    out_src[EV_DATA] = core_in.data_detect;
  end

  // a pin acts as an input only while its direction bit is clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign in_act[gi] = ~st_ff.dir[gi] & st_ff.pin_s2[gi];
    end
    for (gi = 0; gi < NUM_EVT_PINS; gi++) begin : g_sel
      logic [1:0] sel;
      assign sel = st_ff.func[2*gi +: 2];
      assign chan_en[gi] = in_act[gi] & (sel == SEL_CHAN);
      assign evt_req[gi] = in_act[gi] & (sel == SEL_EVENT);
      assign alt_req[gi] = in_act[gi] & (sel == SEL_ALT);
    end
  endgenerate
  assign chan_en[EV_FIVE] = in_act[EV_FIVE];

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_RST_LSB +: 2] = st_ff.rst_st;
    stat_word[ST_BOOT_LSB +: 2] = st_ff.boot;
    stat_word[ST_DBG] = st_ff.dbg_mode;
    stat_word[ST_HOST] = st_ff.host_on;
    stat_word[ST_BUS32] = st_ff.host_on;
    stat_word[ST_PIN_LSB +: NUM_PINS] = st_ff.pin_s2;
    case (avs_address)
      REG_DIR: rd_mux = {25'h0, st_ff.dir};
      REG_FUNC: rd_mux = {21'h0, st_ff.func};
      REG_STAT: rd_mux = stat_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : be_merge

  assign bus_req = avs_read | avs_write;

  always_comb begin
    logic por_act;
    logic [31:0] wv;
    por_act = 1'b0;
    wv = 32'h0000_0000;
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.por_s1 = power_on_reset_n_in;
      nxt_st.por_s2 = st_ff.por_s1;
      nxt_st.por_d = st_ff.por_s2;
      nxt_st.hrd_s1 = hard_reset_line_in_n;
      nxt_st.hrd_s2 = st_ff.hrd_s1;
      nxt_st.srs_s1 = soft_reset_line_in_n;
      nxt_st.srs_s2 = st_ff.srs_s1;
      nxt_st.dbr_s1 = debug_request_in;
      nxt_st.dbr_s2 = st_ff.dbr_s1;
      nxt_st.hpe_s1 = host_port_enable_in;
      nxt_st.hpe_s2 = st_ff.hpe_s1;
      nxt_st.btm_s1 = boot_mode_in;
      nxt_st.btm_s2 = st_ff.btm_s1;
      nxt_st.pin_s1 = event_pin_in;
      nxt_st.pin_s2 = st_ff.pin_s1;
      por_act = ~st_ff.por_s2;
      // power-on first, then hard, then soft
      if (por_act) begin
        nxt_st.rst_st = RST_POR;
      end else if (~st_ff.hrd_s2) begin
        nxt_st.rst_st = RST_HARD;
      end else if (~st_ff.srs_s2) begin
        nxt_st.rst_st = RST_SOFT;
      end else begin
        nxt_st.rst_st = RST_RUN;
      end
      // the device stretches its own reset onto the open-drain lines
      nxt_st.drv_hrd = por_act;
      nxt_st.drv_srs = por_act | ~st_ff.hrd_s2;
      if (por_act) begin
        nxt_st.host_on = st_ff.hpe_s2;
        nxt_st.dbg_mode = 1'b0;
        nxt_st.dir = DIR_RESET;
        nxt_st.func = FUNC_RESET;
      end else if (~st_ff.por_d) begin
        nxt_st.dbg_mode = st_ff.dbr_s2;
        nxt_st.boot = st_ff.btm_s2;
      end
      if (~st_ff.hrd_s2 & ~por_act) begin
        nxt_st.dir = DIR_RESET;
        nxt_st.func = FUNC_RESET;
      end
      // registered pin outputs: one cycle per event cycle
      nxt_st.pin_out = st_ff.dir & out_src;
      nxt_st.cout.addr_chan_enable = chan_en;
      nxt_st.cout.data_chan_enable = in_act[EV_DATA];
      nxt_st.cout.debug_event = evt_req;
      nxt_st.cout.debug_req = alt_req[EV_ZERO];
      nxt_st.cout.event_counter_enable = alt_req[EV_TWO];
      // two-cycle register access: waitrequest drops on the second cycle
      if (bus_req & ~st_ff.ack) begin
        nxt_st.ack = 1'b1;
        nxt_st.rdata = avs_read ? rd_mux : st_ff.rdata;
      end else if (st_ff.ack) begin
        nxt_st.ack = 1'b0;
        if (avs_write & ~por_act & st_ff.hrd_s2) begin
          case (avs_address)
            REG_DIR: begin
              wv = be_merge({25'h0, st_ff.dir}, avs_writedata,
                            avs_byteenable);
              nxt_st.dir = wv[NUM_PINS-1:0];
            end
            REG_FUNC: begin
              wv = be_merge({21'h0, st_ff.func}, avs_writedata,
                            avs_byteenable);
              nxt_st.func = wv[FUNC_W-1:0];
            end
            default: nxt_st.func = st_ff.func;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.por_s1 <= 1'b0;
      st_ff.hrd_s1 <= 1'b1;
      st_ff.hrd_s2 <= 1'b1;
      st_ff.srs_s1 <= 1'b1;
      st_ff.srs_s2 <= 1'b1;
      st_ff.rst_st <= RST_POR;
      st_ff.drv_hrd <= 1'b1;
      st_ff.drv_srs <= 1'b1;
      st_ff.dir <= DIR_RESET;
      st_ff.func <= FUNC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hard_reset_line_out = 1'b0;
  assign hard_reset_line_oe_n = ~st_ff.drv_hrd;
  assign soft_reset_line_out = 1'b0;
  assign soft_reset_line_oe_n = ~st_ff.drv_srs;
  assign event_pin_out = st_ff.pin_out;
  assign event_pin_oe_n = ~st_ff.dir;
  assign core_out = st_ff.cout;
  assign reset_state = st_ff.rst_st;
  assign debug_mode = st_ff.dbg_mode;
  assign boot_mode = st_ff.boot;
  assign host_port_on = st_ff.host_on;
  assign bus_is_32 = st_ff.host_on;
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = bus_req & ~(st_ff.ack & clk_en);

  // checks
  sequence s_por_held;
    clk_en & ~st_ff.por_s2;
  endsequence

  sequence s_por_release;
    clk_en & ~st_ff.por_d & st_ff.por_s2;
  endsequence

  property p_por_state;
    @(posedge clk_sys) disable iff (sys_rst)
    s_por_held |=> (reset_state == RST_POR);
  endproperty
  a_por_state: assert property (p_por_state)
    else $error("power-on reset did not give power-on state");

  property p_hard_state;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & st_ff.por_s2 & ~st_ff.hrd_s2 |=> (reset_state == RST_HARD);
  endproperty
  a_hard_state: assert property (p_hard_state)
    else $error("hard reset line did not give hard state");

  property p_soft_state;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & st_ff.por_s2 & st_ff.hrd_s2 & ~st_ff.srs_s2
      |=> (reset_state == RST_SOFT);
  endproperty
  a_soft_state: assert property (p_soft_state)
    else $error("soft reset line did not give soft state");

  property p_prio;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & ~st_ff.por_s2 & ~st_ff.hrd_s2 & ~st_ff.srs_s2
      |=> (reset_state == RST_POR);
  endproperty
  a_prio: assert property (p_prio)
    else $error("reset priority broken");

  property p_dbg_strap;
    @(posedge clk_sys) disable iff (sys_rst)
    s_por_release |=> (debug_mode == $past(st_ff.dbr_s2));
  endproperty
  a_dbg_strap: assert property (p_dbg_strap)
    else $error("debug request not taken at power-on release");

  property p_boot_strap;
    @(posedge clk_sys) disable iff (sys_rst)
    s_por_release |=> (boot_mode == $past(st_ff.btm_s2));
  endproperty
  a_boot_strap: assert property (p_boot_strap)
    else $error("boot mode not taken at power-on release");

  property p_host_strap;
    @(posedge clk_sys) disable iff (sys_rst)
    s_por_held |=> (host_port_on == $past(st_ff.hpe_s2))
                   & (bus_is_32 == host_port_on);
  endproperty
  a_host_strap: assert property (p_host_strap)
    else $error("host port strap not followed");

  property p_dir_default;
    @(posedge clk_sys) disable iff (sys_rst)
    s_por_held |=> (event_pin_oe_n == OE_N_ALL) [*2];
  endproperty
  a_dir_default: assert property (p_dir_default)
    else $error("event pin not an input after power-on");

  property p_pin_zero_out;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & st_ff.dir[EV_ZERO] & core_in.addr_detect[0]
      |=> event_pin_out[EV_ZERO];
  endproperty
  a_pin_zero_out: assert property (p_pin_zero_out)
    else $error("channel 0 detection missing on pin zero");

  property p_rcv_out;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & st_ff.dir[EV_THREE] & core_in.debug_rcv_read
      |=> event_pin_out[EV_THREE];
  endproperty
  a_rcv_out: assert property (p_rcv_out)
    else $error("receive read not shown on pin three");

  property p_xmt_out;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & st_ff.dir[EV_FOUR] & core_in.debug_xmt_write
      |=> event_pin_out[EV_FOUR];
  endproperty
  a_xmt_out: assert property (p_xmt_out)
    else $error("transmit write not shown on pin four");

  property p_data_out;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & st_ff.dir[EV_DATA] & core_in.data_detect
      |=> event_pin_out[EV_DATA];
  endproperty
  a_data_out: assert property (p_data_out)
    else $error("data match not shown on data pin");

  property p_dbg_req_in;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & alt_req[EV_ZERO]
      |=> core_out.debug_req & ~core_out.debug_event[0];
  endproperty
  a_dbg_req_in: assert property (p_dbg_req_in)
    else $error("pin zero debug request not passed on");

  property p_pin_five_in;
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en & ~st_ff.dir[EV_FIVE] & st_ff.pin_s2[EV_FIVE]
      |=> core_out.addr_chan_enable[EV_FIVE];
  endproperty
  a_pin_five_in: assert property (p_pin_five_in)
    else $error("pin five did not enable channel 5");

endmodule : rbd_top
`default_nettype wire

// >>> tb.sv
// tb: register and pin level tests of the reset and event pin block.
// assumes the board model for the open-drain lines and the event pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rbd_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic por_n = 1'b0;
  logic ext_hard_n = 1'b1;
  logic ext_soft_n = 1'b1;
  logic dbg_req = 1'b1;
  logic host_en = 1'b1;
  logic [1:0] boot_in = 2'h2;
  logic [NUM_PINS-1:0] equip = 7'h00;
  rbd_core_in_s core_in = '0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic hard_out, hard_oe_n, soft_out, soft_oe_n, hard_n, soft_n;
  logic [NUM_PINS-1:0] pin_out, pin_oe_n, pin_level;
  rbd_core_out_s core_out;
  rbd_rst_e reset_state;
  logic debug_mode, host_on, bus32, waitreq;
  logic [1:0] boot_mode;
  logic [31:0] rdata;
  int mismatches = 0;
  int n_checks = 0;

  rbd_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .power_on_reset_n_in(por_n), .hard_reset_line_in_n(hard_n),
    .hard_reset_line_out(hard_out), .hard_reset_line_oe_n(hard_oe_n),
    .soft_reset_line_in_n(soft_n), .soft_reset_line_out(soft_out),
    .soft_reset_line_oe_n(soft_oe_n), .debug_request_in(dbg_req),
    .host_port_enable_in(host_en), .boot_mode_in(boot_in),
    .event_pin_in(pin_level), .event_pin_out(pin_out),
    .event_pin_oe_n(pin_oe_n), .core_in(core_in), .core_out(core_out),
    .reset_state(reset_state), .debug_mode(debug_mode),
    .boot_mode(boot_mode), .host_port_on(host_on), .bus_is_32(bus32),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(waitreq));

  rbd_board u_board (.hard_out(hard_out), .hard_oe_n(hard_oe_n),
    .soft_out(soft_out), .soft_oe_n(soft_oe_n), .ext_hard_n(ext_hard_n),
    .ext_soft_n(ext_soft_n), .hard_n(hard_n), .soft_n(soft_n),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .equip_drive(equip),
    .pin_level(pin_level));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_st(rbd_rst_e exp);
    n_checks++;
    if (reset_state !== exp) begin
      mismatches++;
      $display("wrong value reset_state expected %s seen %h", exp.name(),
               reset_state);
    end
  endtask : chk_st

  // one Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= wd;
    // waitrequest and readdata are looked at as they stood at this edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rd = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) mismatches++;
  endtask : bus

  task automatic wr(logic [3:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(string what, logic [3:0] a, logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask : rd_chk

  task automatic wait_st(rbd_rst_e s);
    int n;
    n = 0;
    while (reset_state !== s && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk_st(s);
  endtask : wait_st

  // one-cycle core source pulse; pin must follow for exactly one cycle
  task automatic pulse(logic [9:0] v, logic [NUM_PINS-1:0] exp);
    @(posedge clk_sys);
    core_in <= v;
    @(posedge clk_sys);
    core_in <= '0;
    #1 chk("event_pin_out", 32'(exp), 32'(pin_out));
    @(posedge clk_sys);
    #1 chk("event_pin_out after", 32'h0, 32'(pin_out));
  endtask : pulse

  task automatic settle();
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : settle

  initial forever #25 clk_sys = ~clk_sys;

  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    chk_st(RST_POR);
    chk("pin oe_n", 32'(OE_N_ALL), 32'(pin_oe_n));
    chk("hard oe_n", 32'h0, 32'(hard_oe_n));
    @(posedge clk_sys);
    por_n <= 1'b1;
    wait_st(RST_RUN);
    @(posedge clk_sys);
    dbg_req <= 1'b0;
    host_en <= 1'b0;
    boot_in <= 2'h1;
    settle();
    chk("debug_mode", 32'h1, 32'(debug_mode));
    chk("boot_mode", 32'h2, 32'(boot_mode));
    chk("host_port_on", 32'h1, 32'(host_on));
    chk("bus_is_32", 32'h1, 32'(bus32));
    rd_chk("status", REG_STAT, 32'h78);
    rd_chk("dir", REG_DIR, 32'h0);
    rd_chk("func", REG_FUNC, 32'h0);
    rd_chk("unmapped", 4'hC, 32'h0);
    wr(4'hC, 32'hFFFF_FFFF);
    rd_chk("dir", REG_DIR, 32'h0);
    $display("test straps and registers done");
    equip <= 7'h7F;
    settle();
    chk("chan en", 32'h3F,
        32'(core_out.addr_chan_enable));
    chk("data en", 32'h1, 32'(core_out.data_chan_enable));
    rd_chk("status pins", REG_STAT, 32'h3FF8);
    wr(REG_FUNC, 32'h155);
    settle();
    chk("events", 32'h1F,
        32'(core_out.debug_event));
    chk("chan en", 32'h20, 32'(core_out.addr_chan_enable));
    wr(REG_FUNC, 32'h2AA);
    settle();
    chk("debug_req", 32'h1, 32'(core_out.debug_req));
    chk("counter", 32'h1, 32'(core_out.event_counter_enable));
    chk("events", 32'h0, 32'(core_out.debug_event));
    $display("test input functions done");
    wr(REG_DIR, 32'h7F);
    wr(REG_FUNC, 32'h400);
    settle();
    chk("pin oe_n", 32'h0, 32'(pin_oe_n));
    chk("chan en", 32'h0, 32'(core_out.addr_chan_enable));
    pulse(10'h010, 7'h01);
    pulse(10'h004, 7'h02);
    pulse(10'h040, 7'h04);
    pulse(10'h002, 7'h08);
    pulse(10'h080, 7'h00);
    pulse(10'h001, 7'h10);
    pulse(10'h200, 7'h20);
    pulse(10'h008, 7'h40);
    wr(REG_FUNC, 32'h0);
    pulse(10'h020, 7'h02);
    pulse(10'h004, 7'h00);
    $display("test output functions done");
    @(posedge clk_sys);
    equip <= 7'h00;
    clk_en <= 1'b0;
    ext_soft_n <= 1'b0;
    settle();
    chk_st(RST_RUN);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    wait_st(RST_SOFT);
    @(posedge clk_sys);
    ext_hard_n <= 1'b0;
    wait_st(RST_HARD);
    chk("soft oe_n", 32'h0, 32'(soft_oe_n));
    rd_chk("dir cleared", REG_DIR, 32'h0);
    @(posedge clk_sys);
    por_n <= 1'b0;
    wait_st(RST_POR);
    @(posedge clk_sys);
    ext_hard_n <= 1'b1;
    ext_soft_n <= 1'b1;
    settle();
    chk_st(RST_POR);
    @(posedge clk_sys);
    por_n <= 1'b1;
    wait_st(RST_RUN);
    settle();
    chk("debug_mode", 32'h0, 32'(debug_mode));
    chk("boot_mode", 32'h1, 32'(boot_mode));
    chk("host_port_on", 32'h0, 32'(host_on));
    chk("bus_is_32", 32'h0, 32'(bus32));
    $display("test reset states done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
